// ==== rtl/rcad_alu.sv ====
// 8-bit arithmetic and logic unit of the risc core
`timescale 1ns/1ps
`default_nettype none
module rcad_alu
  import rcad_pkg::*;
(
  input wire rcad_alu_op_type op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic carry_in,
  output logic [7:0] result,
  output logic c_out,
  output logic nb_out,
  output logic z_out,
  output logic c_we,
  output logic nb_we,
  output logic z_we
);
  logic [8:0] sum9; // full byte sum with carry
  logic [4:0] nib5; // low nibble sum with nibble carry

  // one function per op; sub is b minus a, done as b + ~a + 1
  always_comb begin
    sum9 = 9'h000;
    nib5 = 5'h00;
    result = 8'h00;
    c_out = carry_in;
    nb_out = 1'b0;
    c_we = 1'b0;
    nb_we = 1'b0;
    z_we = 1'b0;
    unique case (op)
      RCAD_ALU_PASS: result = b;
      RCAD_ALU_MOVE: begin
        result = b;
        z_we = 1'b1;
      end
      RCAD_ALU_ADD: begin
        sum9 = {1'b0, a} + {1'b0, b};
        nib5 = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        result = sum9[7:0];
        c_out = sum9[8];
        nb_out = nib5[4];
        {c_we, nb_we, z_we} = 3'h7;
      end
      RCAD_ALU_SUB: begin
        // carry out of the complement add is high when no borrow
        sum9 = {1'b0, b} + {1'b0, ~a} + 9'h001;
        nib5 = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
        result = sum9[7:0];
        c_out = sum9[8];
        nb_out = nib5[4];
        {c_we, nb_we, z_we} = 3'h7;
      end
      RCAD_ALU_AND: begin
        result = a & b;
        z_we = 1'b1;
      end
      RCAD_ALU_OR: begin
        result = a | b;
        z_we = 1'b1;
      end
      RCAD_ALU_XOR: begin
        result = a ^ b;
        z_we = 1'b1;
      end
      RCAD_ALU_INC: begin
        result = b + 8'h01;
        z_we = 1'b1;
      end
      RCAD_ALU_DEC: begin
        result = b - 8'h01;
        z_we = 1'b1;
      end
      RCAD_ALU_RLC: begin // shift through carry
        result = {b[6:0], carry_in};
        c_out = b[7];
        c_we = 1'b1;
      end
      RCAD_ALU_RRC: begin
        result = {carry_in, b[7:1]};
        c_out = b[0];
        c_we = 1'b1;
      end
      RCAD_ALU_COM: begin
        result = ~b;
        z_we = 1'b1;
      end
      RCAD_ALU_CLR: begin
        result = 8'h00;
        z_we = 1'b1;
      end
      RCAD_ALU_SWAP: result = {b[3:0], b[7:4]};
    endcase
    z_out = (result == 8'h00);
  end
endmodule : rcad_alu
`default_nettype wire

// ==== rtl/rcad_core.sv ====
// risc core: program fetch, two-stage pipeline, accumulator, flags
`timescale 1ns/1ps
`default_nettype none
`include "rcad_defs.svh"
module rcad_core
  import rcad_pkg::*;
#(
  parameter int PROG_DEPTH = `RCAD_PROG_DEPTH,
  parameter int DADDR_W = `RCAD_DADDR_W,
  localparam int PCW = $clog2(PROG_DEPTH)
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic prog_load_en,
  input wire logic [PCW-1:0] prog_load_addr,
  input wire logic [13:0] prog_load_data,
  output logic [10:0] pc_out,
  output logic [13:0] instr_out,
  output logic instr_valid,
  output logic [7:0] acc_out,
  output logic [7:0] status_out,
  output logic exec_done
);
  localparam int PHASES = `RCAD_PHASES;
  localparam logic [1:0] LAST_PH = 2'(PHASES - 1);
  localparam logic [10:0] PC_MASK = 11'(PROG_DEPTH - 1);
  localparam logic [DADDR_W-1:0] IND_A = `RCAD_ADDR_INDIRECT;
  localparam logic [DADDR_W-1:0] PCL_A = `RCAD_ADDR_PCLOW;

  // refuse sizes the program counter, phase count or file address field cannot serve
  initial begin
    if (PROG_DEPTH != 512 && PROG_DEPTH != 1024 &&
        PROG_DEPTH != 2048) begin
      $error("rcad_core: program depth must be 512, 1024 or 2048");
    end
    if (PHASES < 1 || PHASES > 4) begin
      $error("rcad_core: phase count must fit two bits");
    end
    if (DADDR_W != `RCAD_DADDR_W) begin
      $error("rcad_core: file address field is seven bits");
    end
  end

  rcad_core_state_type s_reg; // registered state
  rcad_core_state_type s_next; // next state

  // program memory on chip, only its own bus reaches it
  logic [13:0] prog_mem [PROG_DEPTH];
  logic [13:0] fetch_word; // word on the program bus

  // decode and datapath nets
  logic [1:0] cls; // instruction class
  logic [3:0] sub_op; // function within class
  logic [7:0] lit; // immediate field
  logic [DADDR_W-1:0] faddr; // direct file address
  logic [DADDR_W-1:0] ea; // effective file address
  logic [7:0] fval; // file operand after mapping
  logic [7:0] rf_rdata;
  logic [7:0] rf_status;
  logic [7:0] rf_pointer;
  rcad_alu_op_type alu_op;
  logic [7:0] alu_b;
  logic [7:0] alu_res;
  logic alu_c, alu_nb, alu_z;
  logic alu_c_we, alu_nb_we, alu_z_we;
  logic wr_file; // result to file register
  logic wr_acc; // result to accumulator
  logic cycle_end; // last clock of an instruction cycle
  logic exec_now; // valid instruction retires this clock
  logic br_taken; // branch class taken
  logic pc_write; // file write hits program counter low
  logic flow; // program flow changes
  logic [10:0] flow_pc; // new program counter on a flow change
  logic rf_we;

  // program loading port; the fetch never writes
  always_ff @(posedge clk) begin
    if (ce && prog_load_en) begin
      prog_mem[prog_load_addr] <= prog_load_data;
    end
  end

  // one 14-bit word per fetch, read from the counter
  assign fetch_word = prog_mem[s_reg.pc[PCW-1:0]];

  // instruction fields
  assign cls = s_reg.ir[13:12];
  assign sub_op = s_reg.ir[11:8];
  assign lit = s_reg.ir[7:0];
  assign faddr = s_reg.ir[DADDR_W-1:0];

  // address zero goes through the pointer register
  assign ea = (faddr == IND_A) ? rf_pointer[DADDR_W-1:0] : faddr;

  // file operand; a null indirect reads zero, pc low is live
  always_comb begin
    if (ea == IND_A) begin
      fval = 8'h00;
    end else if (ea == PCL_A) begin
      fval = s_reg.pc[7:0];
    end else begin
      fval = rf_rdata;
    end
  end

  // decode: op, second operand and destination
  always_comb begin
    alu_op = RCAD_ALU_PASS;
    alu_b = s_reg.acc;
    wr_file = 1'b0;
    wr_acc = 1'b0;
    unique case (cls)
      `RCAD_CLS_FILE: begin // file with accumulator
        alu_b = fval;
        wr_file = s_reg.ir[`RCAD_DEST_BIT];
        wr_acc = !s_reg.ir[`RCAD_DEST_BIT];
        unique case (sub_op)
          4'h0: begin // store accumulator
            alu_b = s_reg.acc;
            wr_file = 1'b1;
            wr_acc = 1'b0;
          end
          4'h1: alu_op = RCAD_ALU_MOVE;
          4'h2: alu_op = RCAD_ALU_ADD;
          4'h3: alu_op = RCAD_ALU_SUB; // subtract_from_file
          4'h4: alu_op = RCAD_ALU_AND;
          4'h5: alu_op = RCAD_ALU_OR;
          4'h6: alu_op = RCAD_ALU_XOR;
          4'h7: alu_op = RCAD_ALU_INC;
          4'h8: alu_op = RCAD_ALU_DEC;
          4'h9: alu_op = RCAD_ALU_RLC;
          4'ha: alu_op = RCAD_ALU_RRC;
          4'hb: alu_op = RCAD_ALU_COM;
          4'hc: alu_op = RCAD_ALU_CLR;
          4'hd: alu_op = RCAD_ALU_SWAP;
          4'he, 4'hf: begin // no operation
            wr_file = 1'b0;
            wr_acc = 1'b0;
          end
        endcase
      end
      `RCAD_CLS_LIT: begin // literal with accumulator
        alu_b = lit;
        wr_acc = 1'b1;
        unique case (sub_op)
          4'h0: alu_op = RCAD_ALU_PASS;
          4'h1: alu_op = RCAD_ALU_ADD;
          4'h2: alu_op = RCAD_ALU_SUB; // subtract_from_literal
          4'h3: alu_op = RCAD_ALU_AND;
          4'h4: alu_op = RCAD_ALU_OR;
          4'h5: alu_op = RCAD_ALU_XOR;
          4'h6, 4'h7, 4'h8, 4'h9: begin // accumulator only
            alu_b = s_reg.acc;
            unique case (sub_op[1:0])
              2'h2: alu_op = RCAD_ALU_RLC;
              2'h3: alu_op = RCAD_ALU_RRC;
              2'h0: alu_op = RCAD_ALU_COM;
              2'h1: alu_op = RCAD_ALU_CLR;
            endcase
          end
          default: wr_acc = 1'b0; // spare codes do nothing
        endcase
      end
      `RCAD_CLS_GOTO, `RCAD_CLS_BRZ: begin
        alu_op = RCAD_ALU_PASS; // branches touch no data
      end
    endcase
  end

  rcad_alu u_alu (
    .op(alu_op),
    .a(s_reg.acc),
    .b(alu_b),
    .carry_in(rf_status[`RCAD_ST_C]),
    .result(alu_res),
    .c_out(alu_c),
    .nb_out(alu_nb),
    .z_out(alu_z),
    .c_we(alu_c_we),
    .nb_we(alu_nb_we),
    .z_we(alu_z_we)
  );

  // timing and flow control
  assign cycle_end = (s_reg.phase == LAST_PH);
  assign exec_now = cycle_end && s_reg.ir_valid;
  assign br_taken = (cls == `RCAD_CLS_GOTO) || ((cls == `RCAD_CLS_BRZ)
    && (rf_status[`RCAD_ST_Z] == s_reg.ir[`RCAD_SENSE_BIT]));
  assign pc_write = wr_file && (ea == PCL_A);
  assign flow = exec_now && (br_taken || pc_write);
  assign flow_pc = (br_taken ? s_reg.ir[10:0]
    : {s_reg.pc[10:8], alu_res}) & PC_MASK;
  // a null indirect write is dropped
  assign rf_we = exec_now && wr_file && (ea != IND_A);

  rcad_regfile #(
    .DADDR_W(DADDR_W)
  ) u_regfile (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .raddr(ea),
    .rdata(rf_rdata),
    .we(rf_we),
    .waddr(ea),
    .wdata(alu_res),
    .flag_we({alu_z_we, alu_nb_we, alu_c_we} & {3{exec_now}}),
    .flag_d({alu_z, alu_nb, alu_c}),
    .status_q(rf_status),
    .pointer_q(rf_pointer)
  );

  // next state: execute current word while the next is fetched
  always_comb begin
    s_next = s_reg;
    s_next.exec_done = 1'b0;
    s_next.phase = cycle_end ? 2'h0 : s_reg.phase + 2'h1;
    if (cycle_end) begin
      s_next.exec_done = s_reg.ir_valid;
      if (exec_now && wr_acc) begin
        s_next.acc = alu_res;
      end
      if (flow) begin
        // fetched word is stale, drop it: a bubble cycle follows
        s_next.pc = flow_pc;
        s_next.ir_valid = 1'b0;
      end else begin
        s_next.ir = fetch_word;
        s_next.ir_valid = 1'b1;
        s_next.pc = (s_reg.pc + 11'h001) & PC_MASK;
      end
    end
  end

  // state register; clock enable low freezes everything
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flops
  assign pc_out = s_reg.pc;
  assign instr_out = s_reg.ir;
  assign instr_valid = s_reg.ir_valid;
  assign acc_out = s_reg.acc;
  assign status_out = rf_status;
  assign exec_done = s_reg.exec_done;

  property p_fetch_word;
    @(posedge clk) disable iff (!rst_b)
    (ce && cycle_end && !flow) |=> (s_reg.ir == $past(fetch_word));
  endproperty
  a_fetch_word: assert property (p_fetch_word)
    else $error("fetched word not latched");

  property p_pc_step;
    @(posedge clk) disable iff (!rst_b)
    (ce && cycle_end && !flow)
      |=> (s_reg.pc == (($past(s_reg.pc) + 11'h001) & PC_MASK));
  endproperty
  a_pc_step: assert property (p_pc_step)
    else $error("program counter did not step");

  property p_cycle_len;
    @(posedge clk) disable iff (!rst_b)
    // a flushed slot retires nothing, so only valid slots are counted
    (ce && s_reg.exec_done) ##1 (ce && s_reg.ir_valid)[*3]
      |=> s_reg.exec_done;
  endproperty
  a_cycle_len: assert property (p_cycle_len)
    else $error("instruction cycle not four clocks");

  property p_flush;
    @(posedge clk) disable iff (!rst_b)
    (ce && flow) |=> (!s_reg.ir_valid && s_reg.pc == $past(flow_pc));
  endproperty
  a_flush: assert property (p_flush)
    else $error("taken branch did not flush");

  property p_indirect;
    @(posedge clk) disable iff (!rst_b)
    (faddr == IND_A) |-> (ea == rf_pointer[DADDR_W-1:0]);
  endproperty
  a_indirect: assert property (p_indirect)
    else $error("indirect address wrong");

  property p_acc_hold;
    @(posedge clk) disable iff (!rst_b)
    !(ce && exec_now && wr_acc) |=> $stable(s_reg.acc);
  endproperty
  a_acc_hold: assert property (p_acc_hold)
    else $error("accumulator changed outside execute");

  property p_add;
    @(posedge clk) disable iff (!rst_b)
    (alu_op == RCAD_ALU_ADD)
      |-> ({alu_c, alu_res} == {1'b0, s_reg.acc} + {1'b0, alu_b});
  endproperty
  a_add: assert property (p_add)
    else $error("add result wrong");

  property p_borrow;
    @(posedge clk) disable iff (!rst_b)
    (alu_op == RCAD_ALU_SUB) |-> ((alu_c == (alu_b >= s_reg.acc))
      && (alu_nb == (alu_b[3:0] >= s_reg.acc[3:0])));
  endproperty
  a_borrow: assert property (p_borrow)
    else $error("borrow flags wrong");

  property p_zero_flag;
    @(posedge clk) disable iff (!rst_b)
    (ce && exec_now && alu_z_we)
      |=> (rf_status[`RCAD_ST_Z] == ($past(alu_res) == 8'h00));
  endproperty
  a_zero_flag: assert property (p_zero_flag)
    else $error("zero flag not updated");
endmodule : rcad_core
`default_nettype wire

// ==== rtl/rcad_defs.svh ====
// shared constants of the risc core datapath: offsets, fields, timing
// What this block does
// - fetch one 14-bit word per instruction cycle
// - fetch of next overlaps execute of current
// - one instruction per 200 ns cycle, except taken branches and pc low writes
// - program memory on chip, 512/1K/2K words
// - special registers, program counter, sit in data space
// - direct and indirect file addressing, orthogonal
// - 8-bit alu: add, subtract, shift, logic
// - arithmetic treats values as two's complement
// - second operand is file register or literal
// - single operand from accumulator or file register
// - 8-bit accumulator, not addressable in data space
// - alu updates carry, nibble carry, zero flags
// - subtract flags act as borrow and nibble borrow
// - special registers except pc low are static storage in array
`ifndef RCAD_DEFS_SVH
`define RCAD_DEFS_SVH
`define RCAD_INSTR_W 14
`define RCAD_DATA_W 8
`define RCAD_PC_MAX_W 11
`define RCAD_PROG_DEPTH 512
`define RCAD_DADDR_W 7
`define RCAD_CLK_PERIOD_NS 50
`define RCAD_INSTR_CYCLE_NS 200
`define RCAD_PHASES \
  ((`RCAD_INSTR_CYCLE_NS + `RCAD_CLK_PERIOD_NS - 1) / `RCAD_CLK_PERIOD_NS)
`define RCAD_ADDR_INDIRECT 7'h00
`define RCAD_ADDR_PCLOW 7'h02
`define RCAD_ADDR_STATUS 7'h03
`define RCAD_ADDR_POINTER 7'h04
`define RCAD_STATUS_RST 8'h18
`define RCAD_ST_C 0
`define RCAD_ST_NB 1
`define RCAD_ST_Z 2
`define RCAD_CLS_FILE 2'h0
`define RCAD_CLS_LIT 2'h1
`define RCAD_CLS_GOTO 2'h2
`define RCAD_CLS_BRZ 2'h3
`define RCAD_DEST_BIT 7
`define RCAD_SENSE_BIT 11
`endif

// ==== rtl/rcad_pkg.sv ====
// types shared by the risc core datapath files
package rcad_pkg;
  // alu functions; pass writes no flag, move sets zero
  typedef enum logic [3:0] {
    RCAD_ALU_PASS, RCAD_ALU_MOVE, RCAD_ALU_ADD, RCAD_ALU_SUB,
    RCAD_ALU_AND, RCAD_ALU_OR, RCAD_ALU_XOR, RCAD_ALU_INC,
    RCAD_ALU_DEC, RCAD_ALU_RLC, RCAD_ALU_RRC, RCAD_ALU_COM,
    RCAD_ALU_CLR, RCAD_ALU_SWAP
  } rcad_alu_op_type;

  // whole state of the core sequencer
  typedef struct packed {
    logic [10:0] pc;
    logic [13:0] ir;
    logic ir_valid;
    logic [7:0] acc;
    logic [1:0] phase;
    logic exec_done;
  } rcad_core_state_type;
endpackage : rcad_pkg

// ==== rtl/rcad_regfile.sv ====
// data memory array holding file and special registers
`timescale 1ns/1ps
`default_nettype none
`include "rcad_defs.svh"
module rcad_regfile
  import rcad_pkg::*;
#(
  parameter int DADDR_W = `RCAD_DADDR_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [DADDR_W-1:0] raddr,
  output logic [7:0] rdata,
  input wire logic we,
  input wire logic [DADDR_W-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [2:0] flag_we,
  input wire logic [2:0] flag_d,
  output logic [7:0] status_q,
  output logic [7:0] pointer_q
);
  localparam int DEPTH = 1 << DADDR_W;
  localparam logic [DADDR_W-1:0] ST_A = `RCAD_ADDR_STATUS;
  localparam logic [DADDR_W-1:0] PT_A = `RCAD_ADDR_POINTER;

  initial begin
    if (DADDR_W < 3 || DADDR_W > 8) begin
      $error("rcad_regfile: data address width out of range");
    end
  end

  logic [7:0] mem [DEPTH]; // static storage, special words too

  // reads are plain array lookups
  assign rdata = mem[raddr];
  assign status_q = mem[ST_A];
  assign pointer_q = mem[PT_A];

  // byte write, then flag bits; flags win over a status write
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mem[ST_A] <= `RCAD_STATUS_RST;
    end else if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      for (int i = 0; i < 3; i++) begin
        if (flag_we[i]) begin
          mem[ST_A][i] <= flag_d[i];
        end
      end
    end
  end
endmodule : rcad_regfile
`default_nettype wire

// ==== test/rcad_core_tb.sv ====
// self-checking bench for the risc core datapath
`timescale 1ns/1ps
`default_nettype none
module rcad_core_tb;
  // one expected retirement: accumulator, flags z/dc/c, ce-clock gap
  typedef struct {
    logic [7:0] acc;
    logic [2:0] fl;
    int gap;
  } rcad_note_type;

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic run_en = 1'b0; // random clock enable only while running
  logic go = 1'b0;
  logic [13:0] image [0:15];
  logic load_en, busy, instr_valid, exec_done, done_d;
  logic [8:0] load_addr;
  logic [13:0] load_data, instr_out;
  logic [10:0] pc_out;
  logic [7:0] acc_out, status_out;
  logic [7:0] acc_m, mem_m; // reference accumulator and file 0x20
  logic c_m, nb_m, z_m; // reference flags
  rcad_note_type q [$]; // expected results, oldest first
  int bad_count = 0;
  int check_count = 0;
  int gap_cnt = 0;

  rcad_core #(.PROG_DEPTH(512), .DADDR_W(7)) rcad_core_inst (
    .clk(clk), .rst_b(rst_b), .ce(ce), .prog_load_en(load_en),
    .prog_load_addr(load_addr), .prog_load_data(load_data),
    .pc_out(pc_out), .instr_out(instr_out), .instr_valid(instr_valid),
    .acc_out(acc_out), .status_out(status_out), .exec_done(exec_done)
  );

  rcad_prog_src rcad_prog_src_inst (
    .clk(clk), .go(go), .image(image), .load_en(load_en),
    .load_addr(load_addr), .load_data(load_data), .busy(busy)
  );

  // 50 ns core clock
  initial begin
    forever #25 clk = ~clk;
  end

  // freeze cycles are sprinkled in, about one clock in four
  always @(posedge clk) begin
    ce <= run_en ? ($urandom_range(3) != 0) : 1'b1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  task automatic note(input int gap);
    q.push_back('{acc_m, {z_m, nb_m, c_m}, gap});
  endtask : note

  // two's complement add with carry out of bits 7 and 3
  task automatic do_add(input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, acc_m} + {1'b0, b};
    c_m = s[8];
    nb_m = ({1'b0, acc_m[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
    acc_m = s[7:0];
    z_m = (acc_m == 8'h00);
  endtask : do_add

  // b minus accumulator; a set flag means no borrow
  task automatic do_sub(input logic [7:0] b);
    c_m = (b >= acc_m);
    nb_m = (b[3:0] >= acc_m[3:0]);
    acc_m = b - acc_m;
    z_m = (acc_m == 8'h00);
  endtask : do_sub

  // watcher: each rising retirement pulse takes the oldest note
  always @(posedge clk) begin
    rcad_note_type n;
    if (!rst_b) begin
      gap_cnt = 0;
      done_d = 1'b0;
    end else begin
      if (exec_done === 1'b1 && done_d !== 1'b1 && q.size() > 0) begin
        n = q.pop_front();
        check(16'(acc_out), 16'(n.acc));
        check(16'(status_out), {8'h00, 5'h03, n.fl});
        if (n.gap != 0) begin
          check(16'(gap_cnt), 16'(n.gap));
        end
        gap_cnt = 0;
      end
      if (ce) begin
        gap_cnt++;
      end
      done_d = exec_done;
    end
  end

  // watchdog: the whole run is a few hundred clocks
  initial begin
    #250000;
    bad_count++;
    test_done();
  end

  initial begin
    logic [7:0] k [0:4];
    for (int i = 0; i < 16; i++) begin
      image[i] = 14'h0000;
    end
    void'($urandom(7));
    repeat (4) @(posedge clk);
    for (int run = 0; run < 3; run++) begin
      rst_b <= 1'b0;
      run_en <= 1'b0;
      for (int i = 0; i < 5; i++) begin
        k[i] = 8'($urandom_range(255));
      end
      acc_m = 8'h00;
      {z_m, nb_m, c_m} = 3'h0;
      image[0] = {2'h1, 4'h0, k[0]}; // load literal
      acc_m = k[0];
      note(0);
      image[1] = {2'h1, 4'h1, k[1]}; // add literal
      do_add(k[1]);
      note(4);
      image[2] = {2'h1, 4'h2, k[2]}; // literal minus acc
      do_sub(k[2]);
      note(4);
      image[3] = {2'h0, 4'h0, 1'b1, 7'h20}; // store to file 0x20
      mem_m = acc_m;
      note(4);
      image[4] = {2'h1, 4'h0, 8'h20}; // pointer value
      acc_m = 8'h20;
      note(4);
      image[5] = {2'h0, 4'h0, 1'b1, 7'h04}; // store to pointer
      note(4);
      image[6] = {2'h1, 4'h0, k[3]};
      acc_m = k[3];
      note(4);
      image[7] = {2'h0, 4'h2, 1'b0, 7'h00}; // add through pointer
      do_add(mem_m);
      note(4);
      image[8] = {2'h0, 4'h3, 1'b0, 7'h20}; // file minus acc, direct
      do_sub(mem_m);
      note(4);
      image[9] = {2'h1, 4'h6, 8'h00}; // rotate acc left through carry
      {c_m, acc_m} = {acc_m, c_m};
      note(4);
      image[10] = {2'h2, 1'b0, 11'd13}; // jump over two words
      note(4);
      image[11] = {2'h1, 4'h0, 8'hee}; // must be flushed
      image[12] = {2'h1, 4'h0, 8'hee}; // never reached
      image[13] = {2'h1, 4'h5, k[4]}; // xor literal
      acc_m = acc_m ^ k[4];
      z_m = (acc_m == 8'h00);
      note(8);
      image[14] = {2'h2, 1'b0, 11'd14}; // park
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (2) @(posedge clk);
      for (int i = 0; i < 40 && busy; i++) begin
        @(posedge clk);
      end
      repeat (2) @(posedge clk);
      #1;
      check(16'(pc_out), 16'h0000);
      check(16'(instr_out), 16'h0000);
      check(16'(instr_valid), 16'h0000);
      check(16'(acc_out), 16'h0000);
      check(16'(status_out), 16'h0018);
      check(16'(exec_done), 16'h0000);
      @(posedge clk);
      rst_b <= 1'b1;
      run_en <= 1'b1;
      for (int i = 0; i < 600 && q.size() > 0; i++) begin
        @(posedge clk);
      end
      check(16'(q.size()), 16'h0000);
      check(16'(instr_out), 16'(image[14]));
    end
    test_done();
  end
endmodule : rcad_core_tb
`default_nettype wire

// ==== test/rcad_prog_src.sv ====
// program source model: writes a 16-word image into program memory
`timescale 1ns/1ps
`default_nettype none
module rcad_prog_src (
  input wire logic clk,
  input wire logic go,
  input var logic [13:0] image [0:15],
  output logic load_en,
  output logic [8:0] load_addr,
  output logic [13:0] load_data,
  output logic busy
);
  logic [4:0] idx; // next image word to send

  initial begin
    load_en = 1'b0;
    load_addr = 9'h000;
    load_data = 14'h0000;
    busy = 1'b0;
    idx = 5'h00;
  end

  // one whole 14-bit word per clock; idle data toggles so stale words
  // can never pass for a fresh write
  always @(posedge clk) begin
    if (busy) begin
      load_en <= 1'b1;
      load_addr <= 9'(idx);
      load_data <= image[idx[3:0]];
      idx <= idx + 5'h01;
      if (idx == 5'h0f) begin
        busy <= 1'b0;
      end
    end else begin
      load_en <= 1'b0;
      load_data <= ~load_data;
      if (go) begin
        busy <= 1'b1;
        idx <= 5'h00;
      end
    end
  end
endmodule : rcad_prog_src
`default_nettype wire
